// ==== common/adss_pkg.sv ====
// Shared constants and types for the converter sequencer block
package adss_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL = 10'h000;
    localparam logic [9:0] IDX_RESULT = 10'h001;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h002;
    localparam logic [9:0] IDX_IRQ_CLEAR = 10'h003;
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h004;
    localparam logic [9:0] IDX_PIN_CONFIG = 10'h09f;
    localparam int ADDR_W = 12;

    // Control register fields
    localparam int CTRL_POWER_BIT = 0;
    localparam int CTRL_GO_BIT = 1;
    localparam int CTRL_CLKSEL_LSB = 2;
    localparam int CTRL_CHAN_LSB = 4;

    // Reset values
    localparam logic [1:0] CLKSEL_RESET = 2'h0;
    localparam logic [1:0] CHAN_RESET = 2'h0;
    localparam logic [1:0] PIN_CONFIG_RESET = 2'h0;
    localparam logic IRQ_ENABLE_RESET = 1'b0;

    // Conversion clock selection codes
    localparam logic [1:0] CLKSEL_DIV2 = 2'h0;
    localparam logic [1:0] CLKSEL_DIV8 = 2'h1;
    localparam logic [1:0] CLKSEL_DIV32 = 2'h2;
    localparam logic [1:0] CLKSEL_RC = 2'h3;

    // Bit period in oscillator cycles for each divided selection
    localparam logic [5:0] TAD_DIV2 = 6'h02;
    localparam logic [5:0] TAD_DIV8 = 6'h08;
    localparam logic [5:0] TAD_DIV32 = 6'h20;

    // Oscillator cycles per instruction cycle
    localparam logic [2:0] INSTR_CYCLE_CLKS = 3'h4;
    // Bit periods of hold capacitor isolation after a conversion
    localparam logic [3:0] RECOVERY_TADS = 4'h2;
    localparam int RESULT_W = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START_DELAY = 3'b001,
        ST_CONVERT = 3'b010,
        ST_RECOVER = 3'b011
    } adss_state_e;

endpackage

// ==== rtl/adss_sequencer.sv ====
// Converter sequencing, result, interrupt and pin configuration logic
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - Conversion survives sleep only with the RC clock selection (code 11).
// - RC selection waits one instruction cycle after go before converting.
// - Completion clears go and loads the result register.
// - Completion in sleep wakes if interrupt enabled; power bit stays set.
// - Non-RC clock plus sleep aborts and powers down; power bit kept.
// - Hold capacitor stays disconnected two bit periods after completion.
// - Hold capacitor is never discharged at conversion end.
// - Any reset restores registers except the result, powers off and aborts conversion.
// - Reset leaves the conversion result register uninitialised.
// - Pin configuration register holds two bits, resets to 00, rest zero.
// - Port bits 0-3 are analog channels; bit 3 may be external reference.
module adss_sequencer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adss_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor state and private RC clock enable
    input wire logic sleep_mode,
    input wire logic rc_tick,
    // Analog front end
    input wire logic cmp_above,
    output logic [7:0] sar_trial,
    output logic [1:0] channel_sel,
    output logic hold_connect,
    output logic converter_active,
    output logic [3:0] analog_pin_en,
    output logic ext_ref_en,
    // Interrupt and wake
    output logic irq,
    output logic wake_req
);

    logic power_on_reg;
    logic go_reg;
    logic [1:0] clksel_reg;
    logic [1:0] chan_reg;
    logic [1:0] pin_cfg_reg;
    logic [adss_pkg::RESULT_W-1:0] result_reg;
    logic irq_status_reg;
    logic irq_enable_reg;
    adss_pkg::adss_state_e state_reg;
    adss_pkg::adss_state_e state_next;
    logic [5:0] div_cnt_reg;
    logic [2:0] instr_cnt_reg;
    logic [3:0] tad_cnt_reg;
    logic [7:0] work_reg;
    logic [7:0] mask_reg;
    logic tad_tick;
    logic sleep_abort;
    logic done_evt;
    logic wr_en;
    logic rd_en;
    logic [2:0] sel;
    logic start_req;
    logic clr_req;
    logic power_eff;
    logic [4:0] pin_map;

    // Decodes a byte address into a register select; 7 means unmapped or misaligned
    function automatic logic [2:0] reg_decode(
        input logic [adss_pkg::ADDR_W-1:0] addr
    );
        logic [9:0] idx;
        idx = addr[adss_pkg::ADDR_W-1:2];
        if (addr[1:0] != 2'h0) begin
            reg_decode = 3'h7;
        end else if (idx == adss_pkg::IDX_CTRL) begin
            reg_decode = 3'h0;
        end else if (idx == adss_pkg::IDX_RESULT) begin
            reg_decode = 3'h1;
        end else if (idx == adss_pkg::IDX_IRQ_STATUS) begin
            reg_decode = 3'h2;
        end else if (idx == adss_pkg::IDX_IRQ_CLEAR) begin
            reg_decode = 3'h3;
        end else if (idx == adss_pkg::IDX_IRQ_ENABLE) begin
            reg_decode = 3'h4;
        end else if (idx == adss_pkg::IDX_PIN_CONFIG) begin
            reg_decode = 3'h5;
        end else begin
            reg_decode = 3'h7;
        end
    endfunction

    // Pin configuration: analog channel mask and reference use
    function automatic logic [4:0] pin_decode(input logic [1:0] cfg);
        case (cfg)
            2'h0: pin_decode = 5'h0f;
            2'h1: pin_decode = 5'h17;
            2'h2: pin_decode = 5'h03;
            default: pin_decode = 5'h00;
        endcase
    endfunction

    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign sel = reg_decode(paddr);
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pslverr = psel && penable && (sel == 3'h7 ||
                     (pwrite && (sel == 3'h1 || sel == 3'h2)) ||
                     (!pwrite && sel == 3'h3));
    // Refused outside idle, so go never stands without a conversion
    assign start_req = wr_en && sel == 3'h0 &&
                       pwdata[adss_pkg::CTRL_GO_BIT] &&
                       pwdata[adss_pkg::CTRL_POWER_BIT] && !go_reg &&
                       state_reg == adss_pkg::ST_IDLE;
    assign clr_req = wr_en && sel == 3'h3 && pwdata[0];

    // Power as it stands after this edge; a start write powers up too
    assign power_eff = (wr_en && sel == 3'h0) ?
                       pwdata[adss_pkg::CTRL_POWER_BIT] : power_on_reg;

    // Non-RC clocks stop in sleep, so the conversion cannot continue
    assign sleep_abort = sleep_mode && clksel_reg != adss_pkg::CLKSEL_RC &&
                         go_reg;
    // Last trial bit is decided on this tick
    assign done_evt = state_reg == adss_pkg::ST_CONVERT && tad_tick &&
                      mask_reg[0];

    // Unselected and write-only registers read as zero
    always_comb begin
        prdata = 32'h0;
        if (rd_en) begin
            case (sel)
                3'h0: begin
                    prdata[adss_pkg::CTRL_POWER_BIT] = power_on_reg;
                    prdata[adss_pkg::CTRL_GO_BIT] = go_reg;
                    prdata[adss_pkg::CTRL_CLKSEL_LSB+:2] = clksel_reg;
                    prdata[adss_pkg::CTRL_CHAN_LSB+:2] = chan_reg;
                end
                3'h1: prdata[adss_pkg::RESULT_W-1:0] = result_reg;
                3'h2: prdata[0] = irq_status_reg;
                3'h4: prdata[0] = irq_enable_reg;
                3'h5: prdata[1:0] = pin_cfg_reg;
                default: prdata = 32'h0;
            endcase
        end
    end

    // Control fields
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            power_on_reg <= 1'b0;
            clksel_reg <= adss_pkg::CLKSEL_RESET;
            chan_reg <= adss_pkg::CHAN_RESET;
        end else if (wr_en && sel == 3'h0) begin
            // Power bit is software's alone; sleep abort leaves it set
            power_on_reg <= pwdata[adss_pkg::CTRL_POWER_BIT];
            clksel_reg <= pwdata[adss_pkg::CTRL_CLKSEL_LSB+:2];
            chan_reg <= pwdata[adss_pkg::CTRL_CHAN_LSB+:2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pin_cfg_reg <= adss_pkg::PIN_CONFIG_RESET;
        end else if (wr_en && sel == 3'h5) begin
            pin_cfg_reg <= pwdata[1:0];
        end
    end

    // Go flag: cleared by completion, abort or power-off
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            go_reg <= 1'b0;
        end else if (done_evt || sleep_abort) begin
            go_reg <= 1'b0;
        end else if (wr_en && sel == 3'h0 &&
                     !pwdata[adss_pkg::CTRL_POWER_BIT]) begin
            go_reg <= 1'b0;
        end else if (start_req) begin
            go_reg <= 1'b1;
        end
    end

    // Result keeps its value through every reset
    always_ff @(posedge ref_clk) begin
        if (done_evt) begin
            result_reg <= work_reg | mask_reg &
                          {8{cmp_above}};
        end
    end

    // Interrupt status; a completion beats a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_status_reg <= 1'b0;
        end else if (done_evt) begin
            irq_status_reg <= 1'b1;
        end else if (clr_req) begin
            irq_status_reg <= 1'b0;
        end
    end

    // Interrupt enable
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_enable_reg <= adss_pkg::IRQ_ENABLE_RESET;
        end else if (wr_en && sel == 3'h4) begin
            irq_enable_reg <= pwdata[0];
        end
    end

    // Level output, high until software clears the status
    assign irq = irq_status_reg && irq_enable_reg;
    assign wake_req = irq && sleep_mode;

    // Bit period enable from the oscillator divider or the RC clock
    // Divider restarts per conversion so the first bit gets a full period
    always_ff @(posedge ref_clk) begin
        if (!rstn || state_reg == adss_pkg::ST_IDLE ||
            state_reg == adss_pkg::ST_START_DELAY) begin
            div_cnt_reg <= 6'h0;
        end else if (tad_tick) begin
            div_cnt_reg <= 6'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 6'h1;
        end
    end

    always_comb begin
        case (clksel_reg)
            adss_pkg::CLKSEL_DIV2:
                tad_tick = div_cnt_reg == adss_pkg::TAD_DIV2 - 6'h1;
            adss_pkg::CLKSEL_DIV8:
                tad_tick = div_cnt_reg == adss_pkg::TAD_DIV8 - 6'h1;
            adss_pkg::CLKSEL_DIV32:
                tad_tick = div_cnt_reg == adss_pkg::TAD_DIV32 - 6'h1;
            // RC ticks come from outside and keep running in sleep
            default: tad_tick = rc_tick;
        endcase
    end

    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            adss_pkg::ST_IDLE: begin
                if (start_req) begin
                    if (pwdata[adss_pkg::CTRL_CLKSEL_LSB+:2] ==
                        adss_pkg::CLKSEL_RC) begin
                        state_next = adss_pkg::ST_START_DELAY;
                    end else begin
                        state_next = adss_pkg::ST_CONVERT;
                    end
                end
            end
            adss_pkg::ST_START_DELAY: begin
                if (instr_cnt_reg == adss_pkg::INSTR_CYCLE_CLKS - 3'h1) begin
                    state_next = adss_pkg::ST_CONVERT;
                end
            end
            adss_pkg::ST_CONVERT: begin
                if (done_evt) begin
                    state_next = adss_pkg::ST_RECOVER;
                end
            end
            adss_pkg::ST_RECOVER: begin
                if (tad_tick && tad_cnt_reg == adss_pkg::RECOVERY_TADS -
                    4'h1) begin
                    state_next = adss_pkg::ST_IDLE;
                end
            end
            default: state_next = adss_pkg::ST_IDLE;
        endcase
        if (sleep_abort || !power_eff) begin
            state_next = adss_pkg::ST_IDLE;
        end
    end

    // Reset drops any conversion in progress
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg <= adss_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Instruction cycle wait before an RC conversion starts
    always_ff @(posedge ref_clk) begin
        if (!rstn || state_reg != adss_pkg::ST_START_DELAY) begin
            instr_cnt_reg <= 3'h0;
        end else begin
            instr_cnt_reg <= instr_cnt_reg + 3'h1;
        end
    end

    // Recovery bit period count
    always_ff @(posedge ref_clk) begin
        if (!rstn || state_reg != adss_pkg::ST_RECOVER) begin
            tad_cnt_reg <= 4'h0;
        end else if (tad_tick) begin
            tad_cnt_reg <= tad_cnt_reg + 4'h1;
        end
    end

    // Successive approximation, most significant bit first
    always_ff @(posedge ref_clk) begin
        if (!rstn || state_reg != adss_pkg::ST_CONVERT) begin
            work_reg <= 8'h00;
            mask_reg <= 8'h80;
        end else if (tad_tick) begin
            if (cmp_above) begin
                work_reg <= work_reg | mask_reg;
            end
            mask_reg <= {1'b0, mask_reg[7:1]};
        end
    end

    assign sar_trial = work_reg | mask_reg;
    assign channel_sel = chan_reg;
    // Powered down in sleep unless the RC clock keeps running
    assign converter_active = power_on_reg &&
                              !(sleep_mode &&
                                clksel_reg != adss_pkg::CLKSEL_RC);
    // Switch opens for conversion and recovery; no discharge path exists
    assign hold_connect = converter_active &&
                          state_reg == adss_pkg::ST_IDLE;
    // One decode feeds both the channel mask and the reference select
    assign pin_map = pin_decode(pin_cfg_reg);
    assign analog_pin_en = pin_map[3:0];
    assign ext_ref_en = pin_map[4];

endmodule

// ==== verif/adss_analog_src.sv ====
// Analog source model feeding the comparator
`timescale 1ns/1ps
module adss_analog_src (
    // Source level and trial code
    input wire logic [7:0] level,
    input wire logic [7:0] sar_trial,
    // Comparator decision
    output logic cmp_above
);
    // Source is taken as settled once the acquisition wait has passed
    assign cmp_above = (level >= sar_trial);
endmodule

// ==== verif/adss_checker.sv ====
// Port assertions for the converter sequencer
`timescale 1ns/1ps
module adss_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adss_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Converter and interrupt
    input wire logic sleep_mode,
    input wire logic hold_connect,
    input wire logic converter_active,
    input wire logic [3:0] analog_pin_en,
    input wire logic ext_ref_en,
    input wire logic [7:0] sar_trial,
    input wire logic irq,
    input wire logic wake_req
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_reset_state: assert property ($rose(rstn) |-> !irq && !hold_connect
        && !converter_active && analog_pin_en == 4'hf && !ext_ref_en
        && sar_trial == 8'h80) else $error("outputs not idle after reset");
    a_wake_level: assert property (wake_req == (irq && sleep_mode))
        else $error("wake request mismatch");
    a_read_idle: assert property (!(psel && penable) |-> prdata == 32'h0)
        else $error("read data outside access");
    a_pin_upper_zero: assert property (psel && penable && !pwrite
        && paddr == 12'h27c |-> prdata[31:2] == 30'h0)
        else $error("pin config upper bits set");
    a_unmapped_err: assert property (psel && penable && paddr == 12'h014
        |-> pslverr) else $error("unmapped access without error");
    a_ref_excl: assert property (ext_ref_en |-> !analog_pin_en[3]
        && analog_pin_en[2:0] == 3'h7) else $error("reference pin map");
    a_hold_power: assert property (hold_connect |-> converter_active)
        else $error("hold connected while powered down");
    a_irq_recovery: assert property ($rose(irq) && !$past(hold_connect)
        && $past(converter_active) |-> (!hold_connect) [*4])
        else $error("hold reconnected too early");
endmodule

bind adss_sequencer adss_checker u_adss_checker (.ref_clk(ref_clk),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .hold_connect(hold_connect),
    .converter_active(converter_active), .analog_pin_en(analog_pin_en),
    .ext_ref_en(ext_ref_en), .sar_trial(sar_trial), .irq(irq),
    .wake_req(wake_req));

// ==== verif/testbench.sv ====
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [adss_pkg::ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic sleep_mode = 1'b0;
    logic rc_tick = 1'b0;
    logic [7:0] level = 8'h00;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, cmp_above, hold_connect, converter_active;
    logic ext_ref_en, irq, wake_req, err;
    logic [7:0] sar_trial;
    logic [1:0] channel_sel;
    logic [3:0] analog_pin_en;
    int num_errors = 0;
    int samples_checked = 0;
    int rc_cnt = 0;

    always #20 ref_clk = ~ref_clk;

    // Private RC clock, one tick every four reference clocks
    always @(posedge ref_clk) begin
        rc_cnt <= (rc_cnt + 1) % 4;
        rc_tick <= (rc_cnt == 3);
    end

    adss_sequencer u_adss_sequencer (.ref_clk(ref_clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_mode(sleep_mode), .rc_tick(rc_tick),
        .cmp_above(cmp_above), .sar_trial(sar_trial),
        .channel_sel(channel_sel), .hold_connect(hold_connect),
        .converter_active(converter_active), .analog_pin_en(analog_pin_en),
        .ext_ref_en(ext_ref_en), .irq(irq), .wake_req(wake_req));
    adss_analog_src u_adss_analog_src (.level(level), .sar_trial(sar_trial),
        .cmp_above(cmp_above));

    task automatic conclude();
        if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string w, input logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", w, e, g);
            num_errors++;
        end
    endtask

    // Holds the request until pready is sampled high
    task automatic apb(input logic wr, logic [11:0] a, logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rdc(input string w, logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(w, e, rdata);
    endtask

    task automatic wait_hold(output int n);
        n = 0;
        while (hold_connect !== 1'b1 && n < 300) begin
            n++;
            @(posedge ref_clk);
        end
    endtask

    task automatic t_pin_cfg();
        logic [3:0] pe [4] = '{4'hf, 4'h7, 4'h3, 4'h0};
        rdc("ctrl", 12'h000, 32'h0);
        rdc("irq_en", 12'h010, 32'h0);
        apb(1'b1, 12'h000, 32'h0000_0022);
        rdc("go_unpowered", 12'h000, 32'h20);
        chk("chan", 32'h2, {30'h0, channel_sel});
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 12'h27c, 32'hffff_fff0 | 32'(c));
            rdc("pin_cfg", 12'h27c, 32'(c));
            chk("pin_en", {28'h0, pe[c]}, {28'h0, analog_pin_en});
            chk("ext_ref", 32'(c == 1), {31'h0, ext_ref_en});
        end
        apb(1'b0, 12'h014, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
    endtask

    task automatic t_convert(input logic [1:0] cs, logic [7:0] v,
                             logic [5:0] conversion_bit_period);
        int n;
        level <= v;
        apb(1'b1, 12'h010, 32'h1);
        apb(1'b1, 12'h000, {28'h0, cs, 2'b11});
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            n++;
            @(posedge ref_clk);
        end
        wait_hold(n);
        chk("recovery", {25'h0, conversion_bit_period, 1'b0}, 32'(n));
        rdc("result", 12'h004, {24'h0, v});
        rdc("ctrl", 12'h000, {28'h0, cs, 2'b01});
        rdc("status", 12'h008, 32'h1);
        apb(1'b1, 12'h00c, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
    endtask

    task automatic t_rc_sleep(input logic en, logic [7:0] v);
        int n;
        level <= v;
        apb(1'b1, 12'h010, {31'h0, en});
        apb(1'b1, 12'h000, 32'h0000_000f);
        sleep_mode <= 1'b1;
        rdata = 32'h0;
        n = 0;
        while (rdata[0] !== 1'b1 && n < 100) begin
            apb(1'b0, 12'h008, 32'h0);
            n++;
        end
        chk("wake", {31'h0, en}, {31'h0, wake_req});
        chk("active", 32'h1, {31'h0, converter_active});
        sleep_mode <= 1'b0;
        rdc("result", 12'h004, {24'h0, v});
        rdc("ctrl", 12'h000, 32'hd);
        apb(1'b1, 12'h00c, 32'h1);
        wait_hold(n);
    endtask

    task automatic t_abort();
        apb(1'b1, 12'h000, 32'h0000_000b);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("active", 32'h0, {31'h0, converter_active});
        sleep_mode <= 1'b0;
        rdc("ctrl", 12'h000, 32'h9);
        rdc("status", 12'h008, 32'h0);
    endtask

    task automatic t_reset_mid(input logic [7:0] last);
        apb(1'b1, 12'h27c, 32'h3);
        level <= 8'h3c;
        apb(1'b1, 12'h000, 32'h0000_000b);
        rdc("go", 12'h000, 32'hb);
        rstn <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rdc("ctrl", 12'h000, 32'h0);
        rdc("pin_cfg", 12'h27c, 32'h0);
        rdc("result", 12'h004, {24'h0, last});
        chk("active", 32'h0, {31'h0, converter_active});
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_pin_cfg();
        t_convert(adss_pkg::CLKSEL_DIV2, 8'ha5, adss_pkg::TAD_DIV2);
        t_convert(adss_pkg::CLKSEL_DIV8, 8'h00, adss_pkg::TAD_DIV8);
        t_convert(adss_pkg::CLKSEL_DIV32, 8'hff, adss_pkg::TAD_DIV32);
        t_rc_sleep(1'b0, 8'h81);
        t_rc_sleep(1'b1, 8'h7e);
        t_abort();
        t_reset_mid(8'h7e);
        conclude();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        conclude();
    end
endmodule
